// ### verilog/cbcs_top.v
// Bus cycle status, lock, ready and hold control
`include "cbcs_defines.vh"

module cbcs_top (
    input wire ref_clk, // System clock, 125 MHz
    input wire arst_n, // Asynchronous reset, low active
    input wire req_valid, // Core asks for a bus cycle
    input wire [`CBCS_TYPE_W-1:0] req_type, // Cycle type
    input wire req_addr_bit1, // Address bit one for cycles other than halt and shutdown
    input wire req_lock_prefix, // Instruction has lock prefix
    input wire req_exchange, // Memory exchange instruction cycle
    input wire req_desc, // Descriptor table access
    input wire req_lock_more, // More locked cycles follow
    output wire req_ready, // Request taken when valid and ready
    output reg cyc_done, // Cycle ended by ready
    input wire ready_n, // Bus ready, low active
    input wire hold_req, // Bus hold request
    output reg hold_grant, // Bus hold granted, never floats
    output wire mem_io_sel_o, // Memory/IO select level
    output wire mem_io_sel_oe, // Memory/IO select enable
    output wire mem_io_sel_keep, // Memory/IO select weak level
    output wire code_intack_select_o, // Code/intack select level
    output wire code_intack_select_oe, // Code/intack select enable
    output wire code_intack_select_keep, // Code/intack select weak level
    output wire lock_n_o, // Bus lock level, low active
    output wire lock_n_oe, // Bus lock enable
    output wire lock_n_keep, // Bus lock weak level
    output reg cycle_status_hi_n, // Status line high, low active
    output reg cycle_status_lo_n, // Status line low, low active
    output reg addr_bit_one, // Address bit one
    output reg in_status // High during the status state
);

    // ****************************************
    // Reset release
    // ****************************************
    // Two flops so every flop leaves reset on one clean edge
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'h0;
            rst_n_q <= 1'h0;
        end else begin
            rst_meta_q <= 1'h1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ****************************************
    // States
    // ****************************************
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_STATUS = 6'h02;
    localparam [5:0] ST_CMD = 6'h04;
    localparam [5:0] ST_FLOAT = 6'h08;
    localparam [5:0] ST_GRANT = 6'h10;
    localparam [5:0] ST_TAKE = 6'h20;

    reg [5:0] state_q;
    reg [5:0] state_d;
    reg [`CBCS_CODE_W-1:0] code_d;
    reg mem_io_q;
    reg cod_q;
    reg lock_n_q;
    reg lock_n_d;
    reg more_q;
    reg addr1_d;
    reg [1:0] float_cnt_q;
    wire take;
    wire lock_req;
    wire drv_en;
    wire hold_take;
    wire cycle_end;
    wire float_start;
    wire lock_end;
    wire [31:0] float_load;

    assign take = req_valid && req_ready;

    // ****************************************
    // Bus events
    // ****************************************
    // Hold is taken only in idle and only with the lock free
    assign hold_take = (state_q == ST_IDLE) && hold_req && lock_n_q;
    // Ready matters only in the command state
    assign cycle_end = (state_q == ST_CMD) && !ready_n;
    assign float_start = (state_d == ST_FLOAT) && (state_q != ST_FLOAT);
    assign float_load = `CBCS_FLOAT_CYCLES - 1;
    // Lock drops with the last locked cycle
    assign lock_end = cycle_end && !more_q;

    // ****************************************
    // Cycle type encoding
    // ****************************************
    always @* begin
        code_d = `CBCS_CODE_IDLE;
        addr1_d = req_addr_bit1;
        case (req_type)
            `CBCS_TYPE_INTACK: begin
                code_d = `CBCS_CODE_INTACK;
            end
            `CBCS_TYPE_HALT: begin
                code_d = `CBCS_CODE_HALT_SHUT;
                addr1_d = 1'h1;
            end
            `CBCS_TYPE_SHUTDOWN: begin
                code_d = `CBCS_CODE_HALT_SHUT;
                addr1_d = 1'h0;
            end
            `CBCS_TYPE_MEM_RD: begin
                code_d = `CBCS_CODE_MEM_RD;
            end
            `CBCS_TYPE_MEM_WR: begin
                code_d = `CBCS_CODE_MEM_WR;
            end
            `CBCS_TYPE_IO_RD: begin
                code_d = `CBCS_CODE_IO_RD;
            end
            `CBCS_TYPE_IO_WR: begin
                code_d = `CBCS_CODE_IO_WR;
            end
            `CBCS_TYPE_FETCH: begin
                code_d = `CBCS_CODE_FETCH;
            end
            default: begin
                code_d = `CBCS_CODE_IDLE;
            end
        endcase
    end

    // Lock sources: prefix, exchange, intack, descriptor access
    assign lock_req = req_lock_prefix || req_exchange || req_desc ||
        (req_type == `CBCS_TYPE_INTACK);

    // ****************************************
    // Bus state machine
    // ****************************************
    // Requests only in idle, and not while a hold is taken with the lock free
    assign req_ready = (state_q == ST_IDLE) && !hold_take;

    // Idle: waits for a request or a hold
    // Status: cycle code on the pins for one cycle
    // Command: held until ready is sampled low
    // Float: drivers off before the grant rises
    // Grant: bus lent out until the request drops
    // Take: one cycle to win the bus back
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_STATUS;
                end else if (hold_take) begin
                    state_d = ST_FLOAT;
                end
            end
            ST_STATUS: begin
                state_d = ST_CMD;
            end
            ST_CMD: begin
                if (cycle_end) begin
                    state_d = ST_IDLE;
                end
            end
            ST_FLOAT: begin
                if (float_cnt_q == 2'h0) begin
                    state_d = ST_GRANT;
                end
            end
            ST_GRANT: begin
                if (!hold_req) begin
                    state_d = ST_TAKE;
                end
            end
            ST_TAKE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_IDLE;
            float_cnt_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (float_start) begin
                float_cnt_q <= float_load[1:0];
            end else if (float_cnt_q != 2'h0) begin
                float_cnt_q <= float_cnt_q - 2'h1;
            end
        end
    end

    // ****************************************
    // Lock tracking
    // ****************************************
    // Lock held from a locked request until its last cycle ends
    always @* begin
        lock_n_d = lock_n_q;
        if (take) begin
            lock_n_d = lock_req ? 1'h0 : lock_n_q;
        end else if (lock_end) begin
            lock_n_d = `CBCS_LOCK_OFF;
        end
    end

    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_n_q <= `CBCS_LOCK_OFF;
            more_q <= 1'h0;
        end else begin
            lock_n_q <= lock_n_d;
            if (take) begin
                more_q <= lock_req && req_lock_more;
            end
        end
    end

    // ****************************************
    // Select pins and address bit
    // ****************************************
    // Levels stand from the status state until the next request
    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mem_io_q <= 1'h1;
            cod_q <= 1'h1;
            addr_bit_one <= 1'h0;
        end else if (take) begin
            mem_io_q <= code_d[2];
            cod_q <= code_d[3];
            addr_bit_one <= addr1_d;
        end
    end

    // ****************************************
    // Status lines
    // ****************************************
    // Status lines active only for the status state
    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cycle_status_hi_n <= 1'h1;
            cycle_status_lo_n <= 1'h1;
            in_status <= 1'h0;
        end else begin
            cycle_status_hi_n <= take ? code_d[1] : 1'h1;
            cycle_status_lo_n <= take ? code_d[0] : 1'h1;
            in_status <= take;
        end
    end

    // ****************************************
    // Handshake outputs
    // ****************************************
    always @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cyc_done <= 1'h0;
            hold_grant <= 1'h0;
        end else begin
            // Ready counts only in the command state, never in hold
            cyc_done <= cycle_end;
            hold_grant <= (state_d == ST_GRANT);
        end
    end

    // ****************************************
    // Floating pins
    // ****************************************
    // Drivers off from float start until hold ends
    assign drv_en = !(state_q == ST_FLOAT || state_q == ST_GRANT);

    wire [2:0] pin_val;
    wire [2:0] pin_o;
    wire [2:0] pin_oe;
    wire [2:0] pin_keep;

    assign pin_val[`CBCS_PIN_MEM_IO] = mem_io_q;
    assign pin_val[`CBCS_PIN_CODE] = cod_q;
    assign pin_val[`CBCS_PIN_LOCK] = lock_n_q;

    cbcs_keeper #(
        .N(3),
        .KEEP_ONE(`CBCS_KEEP_MASK)
    ) u_keeper (
        .clk(ref_clk),
        .rst_n(rst_n_q),
        .drv_val(pin_val),
        .drv_en(drv_en),
        .pin_o(pin_o),
        .pin_oe(pin_oe),
        .keep_o(pin_keep)
    );

    assign mem_io_sel_o = pin_o[`CBCS_PIN_MEM_IO];
    assign mem_io_sel_oe = pin_oe[`CBCS_PIN_MEM_IO];
    assign mem_io_sel_keep = pin_keep[`CBCS_PIN_MEM_IO];
    assign code_intack_select_o = pin_o[`CBCS_PIN_CODE];
    assign code_intack_select_oe = pin_oe[`CBCS_PIN_CODE];
    assign code_intack_select_keep = pin_keep[`CBCS_PIN_CODE];
    assign lock_n_o = pin_o[`CBCS_PIN_LOCK];
    assign lock_n_oe = pin_oe[`CBCS_PIN_LOCK];
    assign lock_n_keep = pin_keep[`CBCS_PIN_LOCK];

endmodule // cbcs_top

// ### verilog/cbcs_defines.vh
// Constants for the bus cycle status, lock and ready block
`ifndef CBCS_DEFINES_VH
`define CBCS_DEFINES_VH

// ****************************************
// Cycle requests from the core
// ****************************************
`define CBCS_TYPE_W 3
`define CBCS_TYPE_INTACK 3'h0
`define CBCS_TYPE_HALT 3'h1
`define CBCS_TYPE_SHUTDOWN 3'h2
`define CBCS_TYPE_MEM_RD 3'h3
`define CBCS_TYPE_MEM_WR 3'h4
`define CBCS_TYPE_IO_RD 3'h5
`define CBCS_TYPE_IO_WR 3'h6
`define CBCS_TYPE_FETCH 3'h7

// ****************************************
// Pin codes {code_intack, mem_io, status_hi, status_lo}
// ****************************************
`define CBCS_CODE_W 4
`define CBCS_CODE_INTACK 4'h0
`define CBCS_CODE_HALT_SHUT 4'h4
`define CBCS_CODE_MEM_RD 4'h5
`define CBCS_CODE_MEM_WR 4'h6
`define CBCS_CODE_IO_RD 4'h9
`define CBCS_CODE_IO_WR 4'hA
`define CBCS_CODE_FETCH 4'hD
`define CBCS_CODE_IDLE 4'hF

// ****************************************
// Reset values, pin positions, keeper mask and float length
// ****************************************
`define CBCS_STATUS_IDLE 2'h3
`define CBCS_LOCK_OFF 1'h1
`define CBCS_PIN_MEM_IO 0
`define CBCS_PIN_CODE 1
`define CBCS_PIN_LOCK 2
`define CBCS_KEEP_MASK 3'h4
`define CBCS_FLOAT_CYCLES 1

`endif

// ### verilog/cbcs_keeper.v
// Float control with weak keeper for the floating bus pins
module cbcs_keeper #(
    parameter N = 3,
    parameter [N-1:0] KEEP_ONE = 3'h4
) (
    input wire clk, // System clock
    input wire rst_n, // Synchronised reset, low active
    input wire [N-1:0] drv_val, // Level to drive
    input wire drv_en, // Drivers on
    output wire [N-1:0] pin_o, // Pin output levels
    output wire [N-1:0] pin_oe, // Pin output enables
    output wire [N-1:0] keep_o // Weakly kept level while floating
);
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_pin
            reg last_q;
            // Remember last driven level
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    last_q <= 1'h1;
                end else if (drv_en) begin
                    last_q <= drv_val[i];
                end
            end
            assign pin_o[i] = drv_val[i];
            assign pin_oe[i] = drv_en;
            if (KEEP_ONE[i]) begin : g_one
                assign keep_o[i] = 1'h1;
            end else begin : g_last
                assign keep_o[i] = last_q;
            end
        end
    endgenerate
endmodule // cbcs_keeper

// ### dv/cbcs_top_assertions.sv
// Bus cycle status checker and its bind
module cbcs_chk (
    input wire ref_clk,
    input wire arst_n,
    input wire req_valid,
    input wire [2:0] req_type,
    input wire req_lock_prefix,
    input wire req_exchange,
    input wire req_desc,
    input wire req_ready,
    input wire cyc_done,
    input wire ready_n,
    input wire hold_req,
    input wire hold_grant,
    input wire mem_io_sel_o,
    input wire mem_io_sel_oe,
    input wire mem_io_sel_keep,
    input wire code_intack_select_o,
    input wire code_intack_select_oe,
    input wire lock_n_o,
    input wire lock_n_oe,
    input wire lock_n_keep,
    input wire cycle_status_hi_n,
    input wire cycle_status_lo_n,
    input wire addr_bit_one,
    input wire in_status
);
    wire take = req_valid && req_ready;
    wire lk = req_lock_prefix || req_exchange || req_desc || req_type == 3'h0;
    wire [3:0] pins = {code_intack_select_o, mem_io_sel_o, cycle_status_hi_n, cycle_status_lo_n};
    // ****************************************
    // Pin code per cycle type
    // ****************************************
    function automatic [3:0] code_of(input [2:0] t);
        case (t)
            3'h0: code_of = 4'h0;
            3'h1, 3'h2: code_of = 4'h4;
            3'h3: code_of = 4'h5;
            3'h4: code_of = 4'h6;
            3'h5: code_of = 4'h9;
            3'h6: code_of = 4'hA;
            default: code_of = 4'hD;
        endcase
    endfunction
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_status_code: assert property (
        in_status |-> $past(take) && pins == code_of($past(req_type))) else $error("bad code");
    chk_status_quiet: assert property (
        !in_status |-> cycle_status_hi_n && cycle_status_lo_n) else $error("status not idle");
    chk_halt_bit: assert property (
        in_status && $past(req_type) inside {3'h1, 3'h2}
        |-> addr_bit_one == ($past(req_type) == 3'h1)) else $error("bad halt bit");
    chk_lock_source: assert property (
        in_status && $past(lk) |-> !lock_n_o) else $error("lock missing");
    chk_hold_float: assert property (
        hold_grant |-> !mem_io_sel_oe && !code_intack_select_oe && !lock_n_oe && !req_ready)
        else $error("driving in hold");
    chk_lock_keep: assert property (
        !lock_n_oe |-> lock_n_keep && lock_n_o) else $error("lock keep low");
    chk_keep_last: assert property (
        $fell(mem_io_sel_oe) |-> mem_io_sel_keep == $past(mem_io_sel_o)) else $error("keep lost");
    chk_grant_order: assert property (
        $rose(hold_grant) |-> !$past(mem_io_sel_oe) && $past(lock_n_o, 2)) else $error("grant early");
    chk_grant_drop: assert property (
        hold_grant && !hold_req |=> !hold_grant && mem_io_sel_oe) else $error("grant stuck");
    chk_ready_end: assert property (
        cyc_done |-> !$past(ready_n) && !$past(hold_grant) && !$past(in_status))
        else $error("done without ready");
endmodule // cbcs_chk

bind cbcs_top cbcs_chk u_chk (.*);

// ### dv/cbcs_wait_model.sv
// Wait-state logic answering bus cycles with ready
module cbcs_wait_model (
    input wire clk, // System clock
    input wire status_hi_n, // Status line high, low active
    input wire status_lo_n, // Status line low, low active
    input wire mem_io, // Memory/IO select
    input wire code_sel, // Code/intack select
    input wire [3:0] waits, // Wait states to insert
    output reg ready_n = 1'b1 // Bus ready, low active
);
    timeunit 1ns;
    timeprecision 1ps;
    reg busy_q = 1'b0;
    reg [3:0] cnt_q = 4'h0;
    wire [3:0] code = {code_sel, mem_io, status_hi_n, status_lo_n};
    // A cycle starts on a status code that is neither idle nor reserved
    wire start = !(status_hi_n && status_lo_n) && code != 4'h1 && code != 4'h2 &&
        code != 4'h8 && code != 4'hC && code != 4'hE;
    always @(negedge clk) begin
        if (busy_q) begin
            ready_n <= (cnt_q != 4'h0);
        end else begin
            ready_n <= ~ready_n; // Released line toggles
        end
    end
    always @(posedge clk) begin
        if (start) begin
            busy_q <= 1'b1;
            cnt_q <= waits;
        end else if (busy_q && !ready_n) begin
            busy_q <= 1'b0;
        end else if (busy_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule // cbcs_wait_model

// ### dv/cbcs_top_test.sv
// Self-checking bench for the bus cycle status block
module cbcs_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    reg ref_clk = 1'b0;
    reg arst_n = 1'b0;
    reg req_valid = 1'b0, req_addr_bit1 = 1'b0, req_lock_prefix = 1'b0, req_exchange = 1'b0;
    reg req_desc = 1'b0, req_lock_more = 1'b0, hold_req = 1'b0;
    reg [2:0] req_type = 3'h0;
    reg [3:0] waits = 4'h0;
    wire req_ready, cyc_done, ready_n, hold_grant, mem_io_sel_o, mem_io_sel_oe, mem_io_sel_keep;
    wire code_intack_select_o, code_intack_select_oe, code_intack_select_keep;
    wire lock_n_o, lock_n_oe, lock_n_keep, cycle_status_hi_n, cycle_status_lo_n;
    wire addr_bit_one, in_status;
    integer miscompares = 0;
    integer num_checks = 0;
    integer i;
    always #4 ref_clk = ~ref_clk;
    cbcs_top uut (.*);
    cbcs_wait_model wm (.clk(ref_clk), .status_hi_n(cycle_status_hi_n),
        .status_lo_n(cycle_status_lo_n), .mem_io(mem_io_sel_o),
        .code_sel(code_intack_select_o), .waits(waits), .ready_n(ready_n));
    // ****************************************
    // Compare and closing
    // ****************************************
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task give_up;
        miscompares = miscompares + 1;
        $display("wrong value at %0t: wait timed out", $time);
        wrap_up;
    endtask
    // ****************************************
    // One bus cycle; l picks the lock source
    // ****************************************
    task cycle(input [2:0] t, input a, input [1:0] l, input m, input [3:0] w);
        integer n;
        for (n = 0; n < 40 && req_ready !== 1'b1; n = n + 1) @(negedge ref_clk);
        if (n == 40) give_up;
        req_valid = 1'b1;
        req_type = t;
        req_addr_bit1 = a;
        req_lock_prefix = l == 2'h1;
        req_exchange = l == 2'h2;
        req_desc = l == 2'h3;
        req_lock_more = m;
        waits = w;
        @(negedge ref_clk);
        req_valid = 1'b0;
        chk(4'(in_status), 4'h1);
        chk(4'(addr_bit_one), 4'(t == 3'h1 || (t != 3'h2 && a)));
        chk(4'(mem_io_sel_o), 4'(!(t == 3'h0 || t == 3'h5 || t == 3'h6)));
        chk(4'(lock_n_o), 4'(l == 2'h0 && t != 3'h0));
        chk(4'(code_intack_select_o), 4'(t >= 3'h5));
        chk({2'h0, cycle_status_hi_n, cycle_status_lo_n},
            {2'h0, t == 3'h4 || t == 3'h6, t == 3'h3 || t == 3'h5 || t == 3'h7});
        for (n = 1; n < 40 && cyc_done !== 1'b1; n = n + 1) @(negedge ref_clk);
        if (n == 40) give_up;
        chk(4'(n), 4'h3 + w);
        chk(4'(lock_n_o), 4'(!m));
    endtask
    task t_types;
        for (i = 0; i < 8; i = i + 1) cycle(i[2:0], i[1], 2'h0, 1'b0, 4'(i % 3));
    endtask
    task t_lock_hold;
        integer n;
        cycle(3'h3, 1'b0, 2'h1, 1'b1, 4'h2);
        hold_req = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(4'(hold_grant), 4'h0);
        cycle(3'h4, 1'b0, 2'h2, 1'b1, 4'h0);
        cycle(3'h5, 1'b0, 2'h3, 1'b0, 4'h1);
        for (n = 0; n < 10 && hold_grant !== 1'b1; n = n + 1) @(negedge ref_clk);
        if (n == 10) give_up;
        chk(4'(n), 4'h2);
        chk({code_intack_select_keep, mem_io_sel_keep, lock_n_keep, req_ready}, 4'hA);
        for (n = 0; n < 6; n = n + 1) begin
            @(negedge ref_clk);
            chk({cyc_done, mem_io_sel_oe, code_intack_select_oe, lock_n_oe}, 4'h0);
        end
        hold_req = 1'b0;
        for (n = 0; n < 10 && hold_grant !== 1'b0; n = n + 1) @(negedge ref_clk);
        if (n == 10) give_up;
        chk({1'b0, mem_io_sel_oe, code_intack_select_oe, lock_n_oe}, 4'h7);
        cycle(3'h7, 1'b1, 2'h0, 1'b0, 4'h0);
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_types;
        t_lock_hold;
        arst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({in_status, hold_grant, lock_n_o, mem_io_sel_oe}, 4'h3);
        arst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        cycle(3'h6, 1'b0, 2'h0, 1'b0, 4'h3);
        wrap_up;
    end
endmodule // cbcs_top_test
